// [rx_lock_source_and_input_select.sv]
/*
 Receive lock-source and input-select control for NUM_CH channels, with an
 AXI4-Lite register slave and a level interrupt for link-fault changes.
 Assumes all pins are asynchronous to clk_sys, analog detector results arrive
 as levels, and clk_sys samples one serial bit per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_lock_source_and_input_select #(
   parameter int NUM_CH = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [rx_lock_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rx_lock_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic detector_enable,
   input wire logic [NUM_CH-1:0] force_local_clock_n,
   input wire logic [NUM_CH-1:0] serial_input_select,
   input wire logic [NUM_CH-1:0] primary_serial_in,
   input wire logic [NUM_CH-1:0] secondary_serial_in,
   input wire logic [NUM_CH-1:0] range_in_limit,
   input wire logic [NUM_CH-1:0] reference_clock_present,
   input wire logic [2*NUM_CH-1:0] amplitude_level,
   input wire logic [2*NUM_CH-1:0] rate_band_select,
   output logic [NUM_CH-1:0] lock_to_reference,
   output logic [NUM_CH-1:0] link_fault_n,
   output logic [NUM_CH-1:0] cdr_serial_bit,
   output logic [2*NUM_CH-1:0] pll_rate_band,
   output logic irq
);
   import rx_lock_pkg::*;

   localparam int SYNC_W = 10 * NUM_CH + 1;

   if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
      $error("NUM_CH must lie between 1 and MAX_CH");
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] a, input logic wr);
      logic hit;
      hit = (a == OFS_CTRL) || (a == OFS_IRQ_ENABLE);
      hit = hit || (wr ? (a == OFS_IRQ_CLEAR) : (a == OFS_STATUS || a == OFS_IRQ_STATUS));
      return hit;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic [NUM_CH-1:0] fl_s;
   logic [NUM_CH-1:0] sel_s;
   logic [NUM_CH-1:0] prim_s;
   logic [NUM_CH-1:0] sec_s;
   logic [NUM_CH-1:0] range_s;
   logic [NUM_CH-1:0] refp_s;
   logic [2*NUM_CH-1:0] amp_s;
   logic [2*NUM_CH-1:0] band_s;
   logic det_en_s;

   // Amplitude and band codes are static or slow; a torn code lasts one cycle
   assign pins_raw = {detector_enable, rate_band_select, amplitude_level,
                      reference_clock_present, range_in_limit, secondary_serial_in,
                      primary_serial_in, serial_input_select, force_local_clock_n};
   assign fl_s = pins_s[0 +: NUM_CH];
   assign sel_s = pins_s[NUM_CH +: NUM_CH];
   assign prim_s = pins_s[2*NUM_CH +: NUM_CH];
   assign sec_s = pins_s[3*NUM_CH +: NUM_CH];
   assign range_s = pins_s[4*NUM_CH +: NUM_CH];
   assign refp_s = pins_s[5*NUM_CH +: NUM_CH];
   assign amp_s = pins_s[6*NUM_CH +: 2*NUM_CH];
   assign band_s = pins_s[8*NUM_CH +: 2*NUM_CH];
   assign det_en_s = pins_s[SYNC_W-1];

   sync_2ff #(.WIDTH(SYNC_W)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .din(pins_raw),
      .dout(pins_s)
   );

   // ------------------------------------------------------------
   // Lock-source decision
   // ------------------------------------------------------------
   logic [NUM_CH-1:0] ctrl_en_q;
   logic [2*NUM_CH-1:0] ctrl_thr_q;
   logic [NUM_CH-1:0] lvl_ok;
   logic [NUM_CH-1:0] det_ok;
   logic [NUM_CH-1:0] td_viol;
   logic [NUM_CH-1:0] lock_q;
   logic [NUM_CH-1:0] lock_d;
   logic [NUM_CH-1:0] fault_n_q;
   logic [NUM_CH-1:0] fault_n_d;
   logic [NUM_CH-1:0] cdr_q;
   logic [NUM_CH-1:0] cdr_d;
   logic [2*NUM_CH-1:0] band_q;
   logic [2*NUM_CH-1:0] band_d;

   always_comb begin
      cdr_d = (sel_s & prim_s) | (~sel_s & sec_s);
      band_d = band_q;
      for (int i = 0; i < NUM_CH; i++) begin
         lvl_ok[i] = amp_s[2*i +: 2] >= ctrl_thr_q[2*i +: 2];
         // Band code 11 is not a legal level; keep the last good band
         if (band_s[2*i +: 2] != BAND_BAD) begin
            band_d[2*i +: 2] = band_s[2*i +: 2];
         end
      end
      if (det_en_s) begin
         det_ok = lvl_ok & range_s & ~td_viol;
      end else begin
         det_ok = range_s;
      end
      lock_d = ~fl_s | ~det_ok;
      fault_n_d = range_s & lvl_ok & ~td_viol & ctrl_en_q & fl_s & refp_s;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lock_q <= '1;
         fault_n_q <= '0;
         cdr_q <= '0;
         band_q <= '0;
      end else begin
         lock_q <= lock_d;
         fault_n_q <= fault_n_d;
         cdr_q <= cdr_d;
         band_q <= band_d;
      end
   end

   // The monitor watches the stream actually routed to recovery
   transition_density_check #(.NUM_CH(NUM_CH)) u_td (
      .clk_sys(clk_sys),
      .rst(rst),
      .bit_in(cdr_d),
      .violation(td_viol)
   );

   // ------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------
   logic [IRQ_W-1:0] irq_st_q;
   logic [IRQ_W-1:0] irq_st_d;
   logic [IRQ_W-1:0] irq_en_q;
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_clr;
   logic irq_q;
   logic irq_d;

   always_comb begin
      irq_event = '0;
      irq_event[IRQ_ONSET_LSB +: NUM_CH] = fault_n_q & ~fault_n_d;
      irq_event[IRQ_RECOVER_LSB +: NUM_CH] = ~fault_n_q & fault_n_d;
      // A new event in the clearing cycle survives the clear
      irq_st_d = (irq_st_q & ~irq_clr) | irq_event;
      irq_d = |(irq_st_d & irq_en_q);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_st_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irq_st_q <= irq_st_d;
         irq_q <= irq_d;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [AXI_ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [NUM_CH-1:0] ctrl_en_d;
   logic [2*NUM_CH-1:0] ctrl_thr_d;
   logic [IRQ_W-1:0] irq_en_d;
   logic [31:0] ctrl_word, status_word, merged;
   logic do_write;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CTRL_EN_LSB +: NUM_CH] = ctrl_en_q;
      ctrl_word[CTRL_THR_LSB +: 2*NUM_CH] = ctrl_thr_q;
      status_word = '0;
      status_word[STAT_LOCK_LSB +: NUM_CH] = lock_q;
      status_word[STAT_FAULT_LSB +: NUM_CH] = ~fault_n_q;
      status_word[STAT_TDV_LSB +: NUM_CH] = td_viol;
      status_word[STAT_LVL_LSB +: NUM_CH] = ~lvl_ok;
      status_word[STAT_BAND_LSB +: 2*NUM_CH] = band_q;
      status_word[STAT_SEL_LSB +: NUM_CH] = sel_s;
   end

   always_comb begin
      awready_d = awready_q;
      wready_d = wready_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      ctrl_en_d = ctrl_en_q;
      ctrl_thr_d = ctrl_thr_q;
      irq_en_d = irq_en_q;
      irq_clr = '0;
      merged = '0;
      if (s_axi_awvalid && awready_q) begin
         awaddr_d = s_axi_awaddr;
         awready_d = 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
         wready_d = 1'b0;
      end
      do_write = !awready_q && !wready_q && !bvalid_q;
      if (do_write) begin
         bvalid_d = 1'b1;
         bresp_d = is_mapped(awaddr_q, 1'b1) ? RESP_OKAY : RESP_SLVERR;
         case (awaddr_q)
            OFS_CTRL: begin
               merged = merge_strb(ctrl_word, wdata_q, wstrb_q);
               ctrl_en_d = merged[CTRL_EN_LSB +: NUM_CH];
               ctrl_thr_d = merged[CTRL_THR_LSB +: 2*NUM_CH];
            end
            OFS_IRQ_ENABLE: begin
               merged = merge_strb({{(32-IRQ_W){1'b0}}, irq_en_q}, wdata_q, wstrb_q);
               irq_en_d = merged[IRQ_W-1:0];
            end
            OFS_IRQ_CLEAR: begin
               merged = merge_strb(32'h0, wdata_q, wstrb_q);
               irq_clr = merged[IRQ_W-1:0];
            end
            default: begin
               merged = '0;
            end
         endcase
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
         awready_d = 1'b1;
         wready_d = 1'b1;
      end
   end

   always_comb begin
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = is_mapped(s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_CTRL: rdata_d = ctrl_word;
            OFS_STATUS: rdata_d = status_word;
            OFS_IRQ_STATUS: rdata_d = {{(32-IRQ_W){1'b0}}, irq_st_q};
            OFS_IRQ_ENABLE: rdata_d = {{(32-IRQ_W){1'b0}}, irq_en_q};
            default: rdata_d = 32'h0;
         endcase
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
         ctrl_en_q <= CTRL_EN_RST[NUM_CH-1:0];
         ctrl_thr_q <= CTRL_THR_RST[2*NUM_CH-1:0];
         irq_en_q <= IRQ_EN_RST;
      end else begin
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         ctrl_en_q <= ctrl_en_d;
         ctrl_thr_q <= ctrl_thr_d;
         irq_en_q <= irq_en_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign lock_to_reference = lock_q;
   assign link_fault_n = fault_n_q;
   assign cdr_serial_bit = cdr_q;
   assign pll_rate_band = band_q;
   assign irq = irq_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence checks_fail_s;
      ##1 ($past(det_en_s) && ($past(fl_s & ~(lvl_ok & range_s & ~td_viol)) & ~lock_q) != '0);
   endsequence
   sequence checks_pass_s;
      ##1 ($past(det_en_s) && ($past(fl_s & lvl_ok & range_s & ~td_viol) & lock_q) != '0);
   endsequence

   force_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
      (~$past(fl_s) & ~lock_q) == '0)
      else $error("forced channel not locked to reference");
   force_fault_a: assert property (@(posedge clk_sys) disable iff (rst)
      (~$past(fl_s) & fault_n_q) == '0)
      else $error("forced channel shows no link fault");
   fault_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
      ($past(~range_s | ~refp_s | td_viol | ~ctrl_en_q | ~lvl_ok) & fault_n_q) == '0)
      else $error("fault cause present but link fault high");
   det_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      not checks_fail_s)
      else $error("failing check did not hold reference lock");
   det_free_a: assert property (@(posedge clk_sys) disable iff (rst)
      not checks_pass_s)
      else $error("all checks valid but still on reference");
   det_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      !det_en_s |=> ((($past(fl_s) & (lock_q ^ ~$past(range_s)))) == '0))
      else $error("detectors off but lock ignores range alone");
   input_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      cdr_q == $past((sel_s & prim_s) | (~sel_s & sec_s)))
      else $error("selected serial input not routed");
   band_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
      band_s[1:0] == BAND_BAD |=> band_q[1:0] == $past(band_q[1:0]))
      else $error("illegal band code changed the band");
endmodule
`default_nettype wire

// [rx_lock_pkg.sv]
/*
 Constants shared by the receive lock-source and input-select block:
 register offsets, field positions, reset values, rate-band codes and
 the transition-density limit. Assumes one 32-bit AXI4-Lite register bus.
*/
// Contract
// - With detectors enabled, level, range and density checks together pick the lock source.
// - With detectors enabled, any failing check holds the PLL on the reference until all pass.
// - A run of 60 serial bits with no transition is a transition-density violation.
// - With the detector enable low, only the range check chooses the lock source.
// - A two-bit threshold per channel sets the amplitude at which the level check passes.
// - While force-local-clock is low, the channel's PLL locks to the reference whatever the input.
// - While force-local-clock is low, the channel's link fault output is low.
// - With force-local-clock high, the PLL recovers the selected input, subject to the checks.
// - A static three-level rate select picks the band 195-400, 400-800 or 800-1500 megabaud.
// - With input select high, the primary serial input feeds the recovery circuit.
// - With input select low, the secondary serial input feeds the recovery circuit.
// - Fault low on bad rate, low level, low density, channel off, forced clock or no reference.
package rx_lock_pkg;
   // ------------------------------------------------------------
   // Bus and register map
   // ------------------------------------------------------------
   localparam int MAX_CH = 4;
   localparam int AXI_ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN_LSB = 0;
   localparam int CTRL_THR_LSB = 8;
   localparam int STAT_LOCK_LSB = 0;
   localparam int STAT_FAULT_LSB = 4;
   localparam int STAT_TDV_LSB = 8;
   localparam int STAT_LVL_LSB = 12;
   localparam int STAT_BAND_LSB = 16;
   localparam int STAT_SEL_LSB = 24;
   localparam int IRQ_ONSET_LSB = 0;
   localparam int IRQ_RECOVER_LSB = 4;
   localparam int IRQ_W = 2 * MAX_CH;
   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [MAX_CH-1:0] CTRL_EN_RST = 4'hf;
   localparam logic [2*MAX_CH-1:0] CTRL_THR_RST = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_EN_RST = 8'h00;
   localparam int TD_LIMIT_BITS = 60;
   localparam int TD_CNT_W = 6;
   // ------------------------------------------------------------
   // Rate band codes of the three-level select
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      BAND_LOW = 2'h0,
      BAND_MID = 2'h1,
      BAND_HIGH = 2'h2,
      BAND_BAD = 2'h3
   } rate_band_t;
   localparam int BAND_LOW_MIN_MBAUD = 195;
   localparam int BAND_MID_MIN_MBAUD = 400;
   localparam int BAND_HIGH_MIN_MBAUD = 800;
   localparam int BAND_HIGH_MAX_MBAUD = 1500;
endpackage

// [sync_2ff.sv]
/*
 Two-stage synchroniser for a vector of asynchronous pins.
 Assumes each bit is an independent level; multi-bit codes must be static.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] out_q;
   logic [WIDTH-1:0] out_d;
   logic [1:0] warm_q;
   logic [1:0] warm_d;

   if (WIDTH < 1) begin : g_bad_width
      $error("sync_2ff needs WIDTH of at least 1");
   end

   // First stage feeds only the second stage
   always_comb begin
      meta_d = din;
      out_d = meta_q;
      warm_d = (warm_q == 2'h3) ? warm_q : warm_q + 2'h1;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q <= '0;
         out_q <= '0;
         warm_q <= 2'h0;
      end else begin
         meta_q <= meta_d;
         out_q <= out_d;
         warm_q <= warm_d;
      end
   end

   assign dout = out_q;

   sync_delay_a: assert property (@(posedge clk_sys) disable iff (rst || warm_q != 2'h3)
      dout == $past(din, 2))
      else $error("synchroniser output is not the input two cycles back");
endmodule
`default_nettype wire

// [transition_density_check.sv]
/*
 Per-channel run-length monitor on the recovered serial bit stream.
 Assumes one serial bit per clock edge on bit_in.
*/
`timescale 1ns/1ps
`default_nettype none
module transition_density_check #(
   parameter int NUM_CH = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [NUM_CH-1:0] bit_in,
   output logic [NUM_CH-1:0] violation
);
   import rx_lock_pkg::*;

   localparam int TD_SPAN = TD_LIMIT_BITS + 1;
   localparam logic [TD_CNT_W-1:0] LIMIT = TD_CNT_W'(TD_LIMIT_BITS);

   logic [TD_CNT_W-1:0] cnt_q [NUM_CH];
   logic [TD_CNT_W-1:0] cnt_d [NUM_CH];
   logic [NUM_CH-1:0] prev_q;
   logic [NUM_CH-1:0] viol_q;
   logic [NUM_CH-1:0] viol_d;

   // Saturating count of bits since the last transition
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         if (bit_in[i] != prev_q[i]) begin
            cnt_d[i] = '0;
         end else if (cnt_q[i] >= LIMIT) begin
            cnt_d[i] = LIMIT;
         end else begin
            cnt_d[i] = cnt_q[i] + TD_CNT_W'(1);
         end
         viol_d[i] = (cnt_d[i] >= LIMIT);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prev_q <= '0;
         viol_q <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            cnt_q[i] <= '0;
         end
      end else begin
         prev_q <= bit_in;
         viol_q <= viol_d;
         for (int i = 0; i < NUM_CH; i++) begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end

   assign violation = viol_q;

   for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
      sequence bit_edge_s;
         bit_in[i] != $past(bit_in[i]);
      endsequence
      td_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
         bit_edge_s |=> !violation[i])
         else $error("density violation held after a transition");
      td_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
         $rose(violation[i]) |-> $past(bit_in[i]) == $past(bit_in[i], TD_SPAN))
         else $error("density violation raised before a full quiet run");
   end
endmodule
`default_nettype wire

// [pin_host_model.sv]
/* Pin-side host model driving both serial inputs of every channel.
   Assumes one serial bit per clk_sys cycle and a bench-driven quiet. */
`timescale 1ns/1ps
`default_nettype none
module pin_host_model (
   input wire logic clk_sys,
   input wire logic quiet,
   output logic [3:0] primary_serial_in,
   output logic [3:0] secondary_serial_in
);
   logic bit_q = 1'b0;
   always_ff @(posedge clk_sys) begin
      if (!quiet) bit_q <= ~bit_q;
   end
   // Quiet lines park apart so the chosen input is visible
   assign primary_serial_in = quiet ? 4'hf : {4{bit_q}};
   assign secondary_serial_in = quiet ? 4'h0 : {4{~bit_q}};
endmodule
`default_nettype wire

// [testbench.sv]
/* Self-checking bench: AXI4-Lite master tasks, pin stimulus, scenarios.
   Assumes pin_host_model and the design package are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rx_lock_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, quiet = 1'b0, irq;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, detector_enable = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pll_rate_band;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, force_local_clock_n = 4'hf, serial_input_select = 4'hf;
   logic [3:0] range_in_limit = 4'hf, reference_clock_present = 4'hf;
   logic [7:0] amplitude_level = 8'hff, rate_band_select = 8'h00;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] primary_serial_in, secondary_serial_in;
   logic [3:0] lock_to_reference, link_fault_n, cdr_serial_bit;
   int n_errors = 0, num_checks = 0;
   always #10 clk_sys = ~clk_sys;
   pin_host_model host_u (.clk_sys, .quiet, .primary_serial_in, .secondary_serial_in);
   rx_lock_source_and_input_select dut_u (.*);
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bound(input int i);
      if (i >= 50) begin
         chk(32'h1, 32'h0);
         end_sim();
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic lk(input logic [3:0] l, input logic [3:0] f);
      chk(32'(lock_to_reference), 32'(l));
      chk(32'(link_fault_n), 32'(f));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      bound(i);
      chk(32'(s_axi_bresp), 32'(r));
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      bound(i);
      chk(s_axi_rdata, d);
      chk(32'(s_axi_rresp), 32'(r));
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic t_force();
      wt(6);
      lk(4'h0, 4'hf);
      force_local_clock_n <= 4'ha;
      wt(5);
      lk(4'h5, 4'ha);
      force_local_clock_n <= 4'hf;
      wt(5);
      lk(4'h0, 4'hf);
      $display("force done");
   endtask
   task automatic t_dens();
      // Violation needs 60 flat bits plus sync and decision edges
      quiet <= 1'b1;
      wt(55);
      lk(4'h0, 4'hf);
      wt(20);
      lk(4'hf, 4'h0);
      quiet <= 1'b0;
      wt(6);
      lk(4'h0, 4'hf);
      detector_enable <= 1'b0;
      quiet <= 1'b1;
      wt(80);
      chk(32'(lock_to_reference), 32'h0);
      quiet <= 1'b0;
      range_in_limit <= 4'h3;
      wt(6);
      lk(4'hc, 4'h3);
      range_in_limit <= 4'hf;
      detector_enable <= 1'b1;
      $display("density done");
   endtask
   task automatic t_level();
      // Let the recovery events of the last scenario land before the clear
      wt(6);
      wr(OFS_IRQ_CLEAR, 32'hff, RESP_OKAY);
      wr(OFS_IRQ_ENABLE, 32'h0f, RESP_OKAY);
      wr(OFS_CTRL, 32'he40f, RESP_OKAY);
      amplitude_level <= 8'h55;
      wt(6);
      lk(4'hc, 4'h3);
      chk(32'(irq), 32'h1);
      rd(OFS_IRQ_STATUS, 32'h0c, RESP_OKAY);
      rd(OFS_STATUS, 32'h0f00c0cc, RESP_OKAY);
      wr(OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
      chk(32'(irq), 32'h0);
      wr(OFS_IRQ_CLEAR, 32'hff, RESP_OKAY);
      amplitude_level <= 8'hff;
      wt(6);
      rd(OFS_IRQ_STATUS, 32'hc0, RESP_OKAY);
      wr(OFS_CTRL, 32'he40e, RESP_OKAY);
      reference_clock_present <= 4'h7;
      wt(6);
      lk(4'h0, 4'h6);
      reference_clock_present <= 4'hf;
      wr(OFS_STATUS, 32'h0, RESP_SLVERR);
      wr(8'h20, 32'h0, RESP_SLVERR);
      rd(OFS_IRQ_CLEAR, 32'h0, RESP_SLVERR);
      rd(OFS_CTRL, 32'he40e, RESP_OKAY);
      $display("level done");
   endtask
   task automatic t_sel();
      quiet <= 1'b1;
      serial_input_select <= 4'h5;
      wt(5);
      chk(32'(cdr_serial_bit), 32'h5);
      serial_input_select <= 4'ha;
      wt(2);
      chk(32'(cdr_serial_bit), 32'h5);
      wt(3);
      chk(32'(cdr_serial_bit), 32'ha);
      quiet <= 1'b0;
      for (int c = 0; c < 3; c++) begin
         rate_band_select <= {4{2'(c)}};
         wt(5);
         chk(32'(pll_rate_band), 32'({4{2'(c)}}));
      end
      rate_band_select <= 8'hff;
      wt(5);
      chk(32'(pll_rate_band), 32'haa);
      $display("select done");
   endtask
   initial begin
      wt(8);
      lk(4'hf, 4'h0);
      rst <= 1'b0;
      rd(OFS_CTRL, 32'h0f, RESP_OKAY);
      t_force();
      t_dens();
      t_level();
      t_sel();
      end_sim();
   end
endmodule
`default_nettype wire
